/* core/ors_seq.sv */
`timescale 1ns/1ns

module ors_seq (
  input wire logic mclk,
  input wire logic reset,
  input wire logic start,
  input wire logic abort,
  input wire logic [7:0] method,
  input wire logic decel_valid,
  input wire logic origin_sw,
  input wire logic rev_limit,
  output logic run,
  output logic dir_fwd,
  output logic speed_high,
  output logic busy,
  output logic done,
  output logic start_err
);
  import ors_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  ors_state_t state;
  ors_state_t next_state;
  ors_method_t meth;
  ors_method_t next_meth;
  logic origin_prev;
  logic next_origin_prev;
  logic next_run;
  logic next_dir_fwd;
  logic next_speed_high;
  logic next_done;
  logic next_start_err;
  logic rise;
  logic fall;
  logic method_ok;

  // inputs are synchronous; edges come from one stored sample
  assign rise = origin_sw & ~origin_prev;
  assign fall = ~origin_sw & origin_prev;
  assign method_ok = (method == METHOD_27) || (method == METHOD_28) ||
                     (method == METHOD_29);
  assign busy = (state != ORS_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  always_comb begin
    next_state = state;
    next_meth = meth;
    next_origin_prev = origin_sw;
    next_done = 1'b0;
    next_start_err = 1'b0;
    unique case (state)
      ORS_IDLE: begin
        if (start && method_ok) begin
          if (method == METHOD_27) begin
            next_meth = ORS_M27;
          end else if (method == METHOD_28) begin
            next_meth = ORS_M28;
          end else begin
            next_meth = ORS_M29;
          end
          if (decel_valid && method == METHOD_28) begin
            next_state = ORS_FWD_LOW_FALL;
          end else if (decel_valid && method == METHOD_29) begin
            next_state = ORS_REV_LOW_FALL;
          end else begin
            // method 27 only has its limit branch here, so it always
            // heads reverse first
            next_state = ORS_REV_HIGH;
          end
        end else if (start) begin
          next_start_err = 1'b1;
        end
      end
      ORS_REV_HIGH: begin
        // limit takes priority over an origin edge in the same cycle
        if (rev_limit) begin
          next_state = ORS_FWD_HIGH;
        end else if (rise && meth == ORS_M28) begin
          next_state = ORS_FWD_LOW_FALL;
        end else if (rise && meth == ORS_M29) begin
          next_state = ORS_REV_LOW_FALL;
        end
      end
      ORS_FWD_HIGH: begin
        if (rise && meth == ORS_M29) begin
          next_state = ORS_REV_LOW_FALL;
        end else if (rise) begin
          next_state = ORS_FWD_LOW_FALL;
        end
      end
      ORS_FWD_LOW_FALL: begin
        if (fall && meth == ORS_M27) begin
          next_state = ORS_IDLE;
          next_done = 1'b1;
        end else if (fall) begin
          next_state = ORS_REV_LOW_RISE;
        end
      end
      ORS_REV_LOW_FALL: begin
        if (fall) begin
          next_state = ORS_FWD_LOW_RISE;
        end
      end
      ORS_REV_LOW_RISE, ORS_FWD_LOW_RISE: begin
        if (rise) begin
          next_state = ORS_IDLE;
          next_done = 1'b1;
        end
      end
      default: begin
        next_state = ORS_IDLE;
      end
    endcase
    // abort drops motion at once and reports no completion
    if (abort) begin
      next_state = ORS_IDLE;
      next_done = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // motion command decode, registered from the next state

  always_comb begin
    next_run = 1'b1;
    next_dir_fwd = DIR_REV;
    next_speed_high = SPD_LOW;
    unique case (next_state)
      ORS_IDLE: begin
        next_run = 1'b0;
      end
      ORS_REV_HIGH: begin
        next_speed_high = SPD_HIGH;
      end
      ORS_FWD_HIGH: begin
        next_dir_fwd = DIR_FWD;
        next_speed_high = SPD_HIGH;
      end
      ORS_FWD_LOW_FALL, ORS_FWD_LOW_RISE: begin
        next_dir_fwd = DIR_FWD;
      end
      ORS_REV_LOW_FALL, ORS_REV_LOW_RISE: begin
        next_dir_fwd = DIR_REV;
      end
      default: begin
        next_run = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= ORS_IDLE;
      meth <= ORS_M27;
      origin_prev <= 1'b0;
      run <= RST_RUN;
      dir_fwd <= RST_DIR;
      speed_high <= RST_SPD;
      done <= 1'b0;
      start_err <= 1'b0;
    end else begin
      state <= next_state;
      meth <= next_meth;
      origin_prev <= next_origin_prev;
      run <= next_run;
      dir_fwd <= next_dir_fwd;
      speed_high <= next_speed_high;
      done <= next_done;
      start_err <= next_start_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_m27_limit_fwd_high;
    @(posedge mclk) disable iff (reset)
    (state == ORS_REV_HIGH && meth == ORS_M27 && rev_limit && !abort)
      |=> (run && dir_fwd == DIR_FWD && speed_high == SPD_HIGH);
  endproperty
  a_m27_limit_fwd_high: assert property (p_m27_limit_fwd_high)
    else $error("method 27 did not turn forward high at limit");

  property p_m27_fall_stop;
    @(posedge mclk) disable iff (reset)
    (state == ORS_FWD_LOW_FALL && meth == ORS_M27 && fall && !abort)
      |=> (!run && done) ##1 !done;
  endproperty
  a_m27_fall_stop: assert property (p_m27_fall_stop)
    else $error("method 27 did not stop on origin fall");

  property p_m28_rise_fwd_low;
    @(posedge mclk) disable iff (reset)
    (state == ORS_REV_HIGH && meth == ORS_M28 && rise && !rev_limit &&
     !abort) |=> (run && dir_fwd == DIR_FWD && speed_high == SPD_LOW);
  endproperty
  a_m28_rise_fwd_low: assert property (p_m28_rise_fwd_low)
    else $error("method 28 did not go forward low on origin rise");

  property p_m28_valid_start;
    @(posedge mclk) disable iff (reset)
    (state == ORS_IDLE && start && method == METHOD_28 && decel_valid &&
     !abort) |=> (run && dir_fwd == DIR_FWD && speed_high == SPD_LOW);
  endproperty
  a_m28_valid_start: assert property (p_m28_valid_start)
    else $error("method 28 with valid point did not start forward low");

  property p_m28_fall_rev_low;
    @(posedge mclk) disable iff (reset)
    (state == ORS_FWD_LOW_FALL && meth == ORS_M28 && fall && !abort)
      |=> (run && dir_fwd == DIR_REV && speed_high == SPD_LOW);
  endproperty
  a_m28_fall_rev_low: assert property (p_m28_fall_rev_low)
    else $error("method 28 did not reverse low on origin fall");

  property p_m29_rise_rev_low;
    @(posedge mclk) disable iff (reset)
    (state == ORS_REV_HIGH && meth == ORS_M29 && rise && !rev_limit &&
     !abort) |=> (run && dir_fwd == DIR_REV && speed_high == SPD_LOW);
  endproperty
  a_m29_rise_rev_low: assert property (p_m29_rise_rev_low)
    else $error("method 29 did not slow in reverse on origin rise");

  property p_m29_valid_start;
    @(posedge mclk) disable iff (reset)
    (state == ORS_IDLE && start && method == METHOD_29 && decel_valid &&
     !abort) |=> (run && dir_fwd == DIR_REV && speed_high == SPD_LOW);
  endproperty
  a_m29_valid_start: assert property (p_m29_valid_start)
    else $error("method 29 with valid point did not start reverse low");

  property p_m29_fwd_high_rise;
    @(posedge mclk) disable iff (reset)
    (state == ORS_FWD_HIGH && meth == ORS_M29 && rise && !abort)
      |=> (run && dir_fwd == DIR_REV && speed_high == SPD_LOW);
  endproperty
  a_m29_fwd_high_rise: assert property (p_m29_fwd_high_rise)
    else $error("method 29 did not reverse low after limit and rise");

  property p_final_rise_stop;
    @(posedge mclk) disable iff (reset)
    (state == ORS_FWD_LOW_RISE && rise && !abort)
      |=> (!run && !busy && done);
  endproperty
  a_final_rise_stop: assert property (p_final_rise_stop)
    else $error("forward low did not stop on origin rise");

  property p_hold_forward_low;
    @(posedge mclk) disable iff (reset)
    (state == ORS_FWD_LOW_RISE && !rise && !abort)
      |=> (run && dir_fwd == DIR_FWD && !done);
  endproperty
  a_hold_forward_low: assert property (p_hold_forward_low)
    else $error("forward low changed without an origin rise");

endmodule // ors_seq

/* pkg/ors_pkg.sv */
package ors_pkg;

  // homing method numbers accepted on the method input
  localparam logic [7:0] METHOD_27 = 8'h1b;
  localparam logic [7:0] METHOD_28 = 8'h1c;
  localparam logic [7:0] METHOD_29 = 8'h1d;

  // direction and speed encodings on the motion outputs
  localparam logic DIR_FWD = 1'b1;
  localparam logic DIR_REV = 1'b0;
  localparam logic SPD_HIGH = 1'b1;
  localparam logic SPD_LOW = 1'b0;

  // reset values of the registered motion outputs run, dir_fwd and speed_high
  localparam logic RST_RUN = 1'b0;
  localparam logic RST_DIR = 1'b0;
  localparam logic RST_SPD = 1'b0;

  typedef enum logic [1:0] {
    ORS_M27,
    ORS_M28,
    ORS_M29
  } ors_method_t;

  typedef enum logic [2:0] {
    ORS_IDLE,
    ORS_REV_HIGH,
    ORS_FWD_HIGH,
    ORS_FWD_LOW_FALL,
    ORS_REV_LOW_FALL,
    ORS_REV_LOW_RISE,
    ORS_FWD_LOW_RISE
  } ors_state_t;

endpackage

/* tb/origin_return_sequencer_27_29_bench.sv */
`timescale 1ns/1ns

module origin_return_sequencer_27_29_bench;
  import ors_pkg::*;
  logic mclk = 0, reset = 1, start = 0, abort = 0, decel_valid = 0, load = 0;
  logic [7:0] method = METHOD_28;
  int load_pos = 200;
  logic origin_sw, rev_limit, run, dir_fwd, speed_high, busy, done, start_err;
  int mismatches = 0, n_tests = 0;

  ors_seq uut (.mclk(mclk), .reset(reset), .start(start), .abort(abort),
    .method(method), .decel_valid(decel_valid), .origin_sw(origin_sw),
    .rev_limit(rev_limit), .run(run), .dir_fwd(dir_fwd),
    .speed_high(speed_high), .busy(busy), .done(done),
    .start_err(start_err));
  ors_switch_model axis (.mclk(mclk), .run(run), .dir_fwd(dir_fwd),
    .speed_high(speed_high), .load(load), .load_pos(load_pos),
    .origin_sw(origin_sw), .rev_limit(rev_limit));

  initial begin
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // phases packed two bits each {dir_fwd, speed_high}, oldest highest
  task automatic home(input logic [7:0] m, input logic dv, input int p,
                      input logic [7:0] exp_seq, input logic exp_org);
    logic [7:0] seq;
    logic [1:0] last;
    int n;
    @(posedge mclk);
    load <= 1'b1;
    load_pos <= p;
    @(posedge mclk);
    load <= 1'b0;
    repeat (3) @(posedge mclk);
    start <= 1'b1;
    method <= m;
    decel_valid <= dv;
    @(posedge mclk);
    start <= 1'b0;
    seq = 8'h00;
    last = 2'h3;
    n = 0;
    while (n < 3000) begin
      #1;
      if (run === 1'b1 && {dir_fwd, speed_high} !== last) begin
        last = {dir_fwd, speed_high};
        seq = {seq[5:0], last};
      end
      if (done === 1'b1) break;
      @(posedge mclk);
      n++;
    end
    check(seq, exp_seq);
    check({4'h0, run, busy, done, origin_sw}, {7'h01, exp_org});
    @(posedge mclk);
    #1;
    // done must be a single-cycle pulse
    check({7'h00, done}, 8'h00);
  endtask

  // refused method, start while busy, abort mid-run
  task automatic misc;
    @(posedge mclk);
    start <= 1'b1;
    method <= 8'h1e;
    @(posedge mclk);
    start <= 1'b0;
    #1;
    check({5'h00, start_err, busy, run}, 8'h04);
    @(posedge mclk);
    start <= 1'b1;
    method <= METHOD_29;
    decel_valid <= 1'b0;
    @(posedge mclk);
    start <= 1'b0;
    repeat (4) @(posedge mclk);
    start <= 1'b1;
    method <= METHOD_28;
    decel_valid <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    #1;
    check({5'h00, run, dir_fwd, speed_high}, 8'h05);
    @(posedge mclk);
    abort <= 1'b1;
    @(posedge mclk);
    abort <= 1'b0;
    #1;
    check({5'h00, run, busy, done}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    home(METHOD_27, 1'b0, 150, 8'h1e, 1'b0);
    home(METHOD_28, 1'b0, 200, 8'h18, 1'b1);
    home(METHOD_28, 1'b1, 110, 8'h08, 1'b1);
    home(METHOD_28, 1'b0, 50, 8'h78, 1'b1);
    home(METHOD_29, 1'b0, 200, 8'h12, 1'b1);
    home(METHOD_29, 1'b1, 110, 8'h02, 1'b1);
    home(METHOD_29, 1'b0, 50, 8'h72, 1'b1);
    misc();
    complete_run();
  end

  // the whole run needs well under 5000 cycles
  initial begin
    #500000;
    mismatches++;
    complete_run();
  end
endmodule // origin_return_sequencer_27_29_bench

/* tb/ors_switch_model.sv */
`timescale 1ns/1ns

// behavioural axis: position moves while run is set, switches follow it
module ors_switch_model #(
  parameter int ORG_LO = 100,
  parameter int ORG_HI = 119,
  parameter int HIGH_STEP = 4
) (
  input wire logic mclk,
  input wire logic run,
  input wire logic dir_fwd,
  input wire logic speed_high,
  input wire logic load,
  input wire integer load_pos,
  output logic origin_sw,
  output logic rev_limit
);
  int pos = 200;
  int step;
  assign step = speed_high ? HIGH_STEP : 1;
  // the motor reacts one edge late, so every event overshoots a little
  always @(posedge mclk) begin
    if (load) begin
      pos <= load_pos;
    end else if (run) begin
      pos <= dir_fwd ? pos + step : pos - step;
    end
  end
  assign origin_sw = (pos >= ORG_LO) && (pos <= ORG_HI);
  assign rev_limit = (pos <= 0);
endmodule // ors_switch_model
